// ---- design/flash_bus_cycle.v ----
// one asynchronous flash read or write cycle on the pins
// assumes the flash needs at most T_CYCLE_NS of strobe width and access time
`timescale 1ns/1ps
`include "flash_status_consts.vh"
module flash_bus_cycle #(
  parameter AW = 22,                          // address width
  parameter DW = 8                            // data width
) (
  input  wire          sys_clk,               // system clock
  input  wire          rst_b,                 // synchronous reset, active low
  input  wire          start,                 // one-cycle request
  input  wire          is_write,              // 1 write, 0 read
  input  wire [AW-1:0] addr,                  // cycle address
  input  wire [DW-1:0] wdata,                 // write data
  input  wire [DW-1:0] dq_sync,               // synchronised data pins
  output reg           busy_q,                // cycle in progress
  output reg           done_q,                // one-cycle end pulse
  output reg  [DW-1:0] rdata_q,               // captured read data
  output reg  [AW-1:0] fl_addr_q,             // address pins
  output reg  [DW-1:0] dq_out_q,              // data out pins
  output reg           dq_oe_q,               // data pin drive enable
  output reg           ce_b_q,                // chip enable, active low
  output reg           oe_b_q,                // output enable, active low
  output reg           we_b_q                 // write enable, active low
);
  // strobe length in clocks, rounded up; plus sync latency on reads
  localparam [7:0] STROBE_CLKS = (`T_CYCLE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [7:0] READ_CLKS   = STROBE_CLKS + 8'h03;
  localparam [2:0] S_IDLE = 3'h1, S_STROBE = 3'h2, S_GAP = 3'h4;
  reg [2:0] state_q;                          // one-hot state
  reg [7:0] cnt_q;                            // strobe counter
  reg       wr_q;                             // latched direction
  // every read ends with both strobes high, forming one whole read cycle
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE; cnt_q <= 8'h00; wr_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0;
      rdata_q <= {DW{1'b0}}; fl_addr_q <= {AW{1'b0}}; dq_out_q <= {DW{1'b0}};
      dq_oe_q <= 1'b0; ce_b_q <= 1'b1; oe_b_q <= 1'b1; we_b_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // start a cycle: chip enable paces the cycle with oe or we
          if (start) begin
            state_q <= S_STROBE; busy_q <= 1'b1; wr_q <= is_write; cnt_q <= 8'h00;
            fl_addr_q <= addr; dq_out_q <= wdata; dq_oe_q <= is_write;
            ce_b_q <= 1'b0; oe_b_q <= is_write; we_b_q <= ~is_write;
          end
        end
        S_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          // end of strobe: the rising write strobe launches status
          if ((wr_q && cnt_q == STROBE_CLKS) || (!wr_q && cnt_q == READ_CLKS)) begin
            state_q <= S_GAP; rdata_q <= dq_sync;
            ce_b_q <= 1'b1; oe_b_q <= 1'b1; we_b_q <= 1'b1;
          end
        end
        S_GAP: begin
          // release data bus one clock after strobes rise
          state_q <= S_IDLE; dq_oe_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

// ---- design/flash_status_consts.vh ----
// constants for the flash status poller: command codes, register map, bit positions, timing
// assumes a parallel nor flash on the pins and a 40 mhz sys_clk
//
// Summary of operation
// - host rereads data after toggle bit stops
// - host polls program or erase sector address
// - reads paced by output or chip enable
// - host reads twice and compares toggle
// - limit flag high: recheck, then fail and reset
// - resumed polling restarts from double read; the resume op here ends after its command write, without polling
`ifndef FLASH_STATUS_CONSTS_VH
`define FLASH_STATUS_CONSTS_VH
// register offsets of the controller
`define REG_CTRL          4'h0
`define REG_ADDR          4'h1
`define REG_WDATA         4'h2
`define REG_STATUS        4'h3
`define REG_RDATA         4'h4
// control register fields
`define CTRL_OP_LSB       0
`define CTRL_OP_MSB       2
`define CTRL_GO_BIT       3
`define CTRL_ABORT_BIT    4
// operation codes
`define OP_READ           3'h0
`define OP_PROGRAM        3'h1
`define OP_SECTOR_ERASE   3'h2
`define OP_CHIP_ERASE     3'h3
`define OP_SUSPEND        3'h4
`define OP_RESUME         3'h5
`define OP_RESET          3'h6
// flash command words and unlock addresses
`define UNLOCK_ADDR1      22'h000555
`define UNLOCK_ADDR2      22'h0002AA
`define UNLOCK_DATA1      8'hAA
`define UNLOCK_DATA2      8'h55
`define CMD_PROGRAM       8'hA0
`define CMD_ERASE_SETUP   8'h80
`define CMD_CHIP_ERASE    8'h10
`define CMD_SECTOR_ERASE  8'h30
`define CMD_SUSPEND       8'hB0
`define CMD_RESUME        8'h30
`define CMD_RESET         8'hF0
// data bit positions of status
`define BIT_POLL          7
`define BIT_TOGGLE_ONE    6
`define BIT_TIME_LIMIT    5
`define BIT_ERASE_WINDOW  3
`define BIT_TOGGLE_TWO    2
// result codes
`define RES_NONE          2'h0
`define RES_OK            2'h1
`define RES_FAIL          2'h2
// bus cycle timing in ns
`define T_CYCLE_NS        100
`define CLK_NS            25
`endif

// ---- design/flash_status_poller.v ----
// host controller: issues flash commands and follows the status polling procedure
// assumes one flash on the pins, a pulled-up ready/busy line, and a 40 mhz sys_clk
`timescale 1ns/1ps
`include "flash_status_consts.vh"
module flash_status_poller #(
  parameter AW         = 22,                  // flash address width
  parameter DW         = 8,                   // flash data width
  parameter MAX_POLLS  = 16'hFFFF             // read limit before declaring hang
) (
  input  wire          sys_clk,               // system clock
  input  wire          rst_b,                 // synchronous reset, active low
  input  wire [3:0]    reg_addr,              // register address
  input  wire [31:0]   reg_wdata,             // register write data
  input  wire          reg_wr,                // write strobe
  input  wire          reg_rd,                // read strobe
  output reg  [31:0]   reg_rdata_q,           // read data, one cycle later
  output wire [AW-1:0] fl_addr,               // flash address pins
  output wire [DW-1:0] dq_out,                // data pins out
  output wire          dq_oe,                 // data pins drive enable
  input  wire [DW-1:0] dq_in,                 // data pins in
  output wire          ce_b,                  // chip enable, active low
  output wire          oe_b,                  // output enable, active low
  output wire          we_b,                  // write enable, active low
  input  wire          ready_busy_output      // open-drain ready/busy pin
);
  localparam [6:0] S_IDLE = 7'h01, S_CMD = 7'h02, S_RD1 = 7'h04, S_RD2 = 7'h08,
                   S_RD3 = 7'h10, S_RESET = 7'h20, S_DONE = 7'h40;
  reg  [6:0]    state_q;                      // one-hot state
  reg  [2:0]    op_q;                         // latched operation
  reg  [AW-1:0] addr_q;                       // target address
  reg  [DW-1:0] wdata_q;                      // program data
  reg  [2:0]    step_q;                       // write cycle index
  reg  [1:0]    result_q;                     // last result code
  reg  [DW-1:0] first_q;                      // first read of a pair
  reg  [DW-1:0] rdata_keep_q;                 // last valid array data
  reg  [15:0]   polls_q;                      // reads spent polling
  reg           abort_q;                      // software stop request
  reg           start_q;                      // bus cycle request
  reg           is_wr_q;                      // bus cycle direction
  reg  [AW-1:0] cyc_addr_q;                   // bus cycle address
  reg  [DW-1:0] cyc_data_q;                   // bus cycle write data
  reg  [DW-1:0] dq_s1_q, dq_s2_q, dq_s3_q;    // data pin synchroniser
  reg  [2:0]    rb_s_q;                       // ready/busy synchroniser
  reg           rb_q;                         // filtered ready/busy
  wire          cyc_busy;                     // bus cycle active
  wire          cyc_done;                     // bus cycle finished
  wire [DW-1:0] cyc_rdata;                    // bus cycle read value
  reg  [2:0]    n_writes;                     // writes in the sequence
  reg  [AW-1:0] seq_addr;                     // address of this write
  reg  [DW-1:0] seq_data;                     // data of this write
  wire          toggled;                      // toggle bit moved
  // bus cycle engine
  flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .sys_clk(sys_clk), .rst_b(rst_b), .start(start_q), .is_write(is_wr_q),
    .addr(cyc_addr_q), .wdata(cyc_data_q), .dq_sync(dq_s3_q),
    .busy_q(cyc_busy), .done_q(cyc_done), .rdata_q(cyc_rdata),
    .fl_addr_q(fl_addr), .dq_out_q(dq_out), .dq_oe_q(dq_oe),
    .ce_b_q(ce_b), .oe_b_q(oe_b), .we_b_q(we_b));
  // three-stage synchronisers; ready/busy changes when stages two and three agree
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      dq_s1_q <= {DW{1'b0}}; dq_s2_q <= {DW{1'b0}}; dq_s3_q <= {DW{1'b0}};
      rb_s_q <= 3'h7; rb_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_in; dq_s2_q <= dq_s1_q; dq_s3_q <= dq_s2_q;
      rb_s_q <= {rb_s_q[1:0], ready_busy_output};
      if (rb_s_q[1] == rb_s_q[2]) rb_q <= rb_s_q[2];
    end
  end
  // command sequence table per operation
  always @* begin
    n_writes = 3'h1; seq_addr = `UNLOCK_ADDR1; seq_data = `CMD_RESET;
    case (op_q)
      `OP_PROGRAM: begin
        n_writes = 3'h4;
        case (step_q)
          3'h0: begin seq_addr = `UNLOCK_ADDR1; seq_data = `UNLOCK_DATA1; end
          3'h1: begin seq_addr = `UNLOCK_ADDR2; seq_data = `UNLOCK_DATA2; end
          3'h2: begin seq_addr = `UNLOCK_ADDR1; seq_data = `CMD_PROGRAM; end
          default: begin seq_addr = addr_q; seq_data = wdata_q; end
        endcase
      end
      `OP_SECTOR_ERASE, `OP_CHIP_ERASE: begin
        n_writes = 3'h6;
        case (step_q)
          3'h0, 3'h3: begin seq_addr = `UNLOCK_ADDR1; seq_data = `UNLOCK_DATA1; end
          3'h1, 3'h4: begin seq_addr = `UNLOCK_ADDR2; seq_data = `UNLOCK_DATA2; end
          3'h2: begin seq_addr = `UNLOCK_ADDR1; seq_data = `CMD_ERASE_SETUP; end
          default: begin
            seq_addr = (op_q == `OP_CHIP_ERASE) ? `UNLOCK_ADDR1 : addr_q;
            seq_data = (op_q == `OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_SECTOR_ERASE;
          end
        endcase
      end
      `OP_SUSPEND: begin seq_addr = addr_q; seq_data = `CMD_SUSPEND; end
      `OP_RESUME:  begin seq_addr = addr_q; seq_data = `CMD_RESUME; end
      default:     begin seq_addr = `UNLOCK_ADDR1; seq_data = `CMD_RESET; end
    endcase
  end
  // toggle bit one compared across the pair of reads
  assign toggled = first_q[`BIT_TOGGLE_ONE] != cyc_rdata[`BIT_TOGGLE_ONE];
  // main sequencer and register writes
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE; op_q <= `OP_READ; addr_q <= {AW{1'b0}}; wdata_q <= {DW{1'b0}};
      step_q <= 3'h0; result_q <= `RES_NONE; first_q <= {DW{1'b0}};
      rdata_keep_q <= {DW{1'b0}}; polls_q <= 16'h0000; abort_q <= 1'b0;
      start_q <= 1'b0; is_wr_q <= 1'b0; cyc_addr_q <= {AW{1'b0}}; cyc_data_q <= {DW{1'b0}};
    end else begin
      start_q <= 1'b0;
      // abort: stop polling; the next poll starts over
      if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_ABORT_BIT]) abort_q <= 1'b1;
      if (reg_wr && reg_addr == `REG_ADDR && state_q == S_IDLE) addr_q <= reg_wdata[AW-1:0];
      if (reg_wr && reg_addr == `REG_WDATA && state_q == S_IDLE) wdata_q <= reg_wdata[DW-1:0];
      case (state_q)
        S_IDLE: begin
          abort_q <= 1'b0;
          if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_GO_BIT]) begin
            op_q <= reg_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB]; step_q <= 3'h0;
            result_q <= `RES_NONE; polls_q <= 16'h0000; state_q <= S_CMD;
          end
        end
        S_CMD: begin
          if (op_q == `OP_READ) begin
            // plain array read, also used outside suspended sectors
            if (!cyc_busy && !start_q && !cyc_done) begin
              start_q <= 1'b1; is_wr_q <= 1'b0; cyc_addr_q <= addr_q;
            end
            if (cyc_done) begin rdata_keep_q <= cyc_rdata; result_q <= `RES_OK; state_q <= S_DONE; end
          end else if (!cyc_busy && !start_q && !cyc_done) begin
            start_q <= 1'b1; is_wr_q <= 1'b1; cyc_addr_q <= seq_addr; cyc_data_q <= seq_data;
          end else if (cyc_done) begin
            if (step_q == n_writes - 3'h1) begin
              // poll at program address or erase sector
              step_q <= 3'h0;
              state_q <= (op_q == `OP_RESET || op_q == `OP_RESUME) ? S_DONE : S_RD1;
              if (op_q == `OP_RESET || op_q == `OP_RESUME) result_q <= `RES_OK;
            end else step_q <= step_q + 3'h1;
          end
        end
        S_RD1, S_RD2, S_RD3: begin
          if (!cyc_busy && !start_q && !cyc_done) begin
            if (abort_q) state_q <= S_DONE;
            else begin start_q <= 1'b1; is_wr_q <= 1'b0; cyc_addr_q <= addr_q; end
          end else if (cyc_done) begin
            polls_q <= polls_q + 16'h0001;
            first_q <= cyc_rdata;
            if (state_q == S_RD1) state_q <= S_RD2;       // first of a pair
            else if (!toggled) begin
              // stopped: finished; the next read holds valid data
              result_q <= `RES_OK; op_q <= `OP_READ; state_q <= S_CMD;
            end else if (state_q == S_RD3 || polls_q == MAX_POLLS) begin
              result_q <= `RES_FAIL; op_q <= `OP_RESET; state_q <= S_RESET;
            end else if (cyc_rdata[`BIT_TIME_LIMIT]) state_q <= S_RD3;
            else if (op_q == `OP_SUSPEND && rb_q) begin
              // suspend reached: ready line released
              result_q <= `RES_OK; state_q <= S_DONE;
            end
          end
        end
        S_RESET: begin
          // reset command back to array read
          if (!cyc_busy && !start_q && !cyc_done) begin
            start_q <= 1'b1; is_wr_q <= 1'b1; cyc_addr_q <= `UNLOCK_ADDR1; cyc_data_q <= `CMD_RESET;
          end
          if (cyc_done) state_q <= S_DONE;
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // register read port, data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!rst_b) reg_rdata_q <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:   reg_rdata_q <= {29'h0, op_q};
        `REG_ADDR:   reg_rdata_q <= {{(32-AW){1'b0}}, addr_q};
        `REG_WDATA:  reg_rdata_q <= {{(32-DW){1'b0}}, wdata_q};
        `REG_STATUS: reg_rdata_q <= {first_q, polls_q, 3'h0, rb_q, result_q,
                                     state_q != S_IDLE, 1'b0};
        `REG_RDATA:  reg_rdata_q <= {{(32-DW){1'b0}}, rdata_keep_q};
        default:     reg_rdata_q <= 32'h0000_0000;
      endcase
    end
  end
endmodule // flash_status_poller

// ---- sim/flash_model.sv ----
// behavioural parallel nor flash: command words, program and erase status bits
// assumes the poller pins; ready/busy is open drain with a pull-up
`timescale 1ns/1ps
module flash_model #(
  parameter BUSY_READS = 3                    // read cycles an operation stays busy
) (
  input  wire [21:0] fl_addr,                 // address pins
  input  wire [7:0]  dq_out,                  // data from the host
  input  wire        ce_b,                    // chip enable, active low
  input  wire        oe_b,                    // output enable, active low
  input  wire        we_b,                    // write enable, active low
  input  wire        stuck,                   // operation never finishes
  output wire [7:0]  dq_in,                   // data to the host
  output wire        ready_busy_output,       // open drain, pulled up
  output int         n_start,                 // operations started
  output int         n_reset                  // reset commands seen
);
  logic [7:0]  mem [int];                     // array, erased reads FF
  logic [7:0]  seq [6];                       // command words of a sequence
  logic [7:0]  pd, last_q, cur;               // program data, last driven, output
  logic [21:0] pa;                            // program address
  int          n = 0, left = 0;               // words taken, reads to go
  logic        busy = 0, ers = 0, tg1 = 0, tg2 = 0, rd = 0, tlim = 0;
  logic        wr = 0;                        // write cycle open
  initial begin
    n_start = 0;
    n_reset = 0;
    last_q = 8'h00;
  end
  // start an embedded operation
  task automatic go();
    busy = 1;
    n = 0;
    left = BUSY_READS;
    tlim = 0;
    n_start++;
  endtask
  assign ready_busy_output = busy ? 1'b0 : 1'b1;
  // status byte replaces array data while busy
  always @* begin
    if (!busy) cur = mem.exists(int'(fl_addr)) ? mem[int'(fl_addr)] : 8'hFF;
    else cur = {ers ? 1'b0 : ~pd[7], tg1, tlim, ers, 1'b0, tg2, 2'b00};
  end
  // a released bus shows the inverse of the last driven byte
  assign dq_in = (!ce_b && !oe_b) ? cur : ~last_q;
  // a write cycle opens with both strobes low
  always @(negedge we_b or negedge ce_b) if (!we_b && !ce_b) wr = 1;
  // command words are taken at the first strobe rise; both may rise together
  always @(posedge we_b or posedge ce_b) if (wr) begin
    wr = 0;
    if (dq_out == 8'hF0) begin  // reset ends any operation
      busy = 0;
      n = 0;
      n_reset++;
    end else if (!busy) begin
      seq[n] = dq_out;
      n++;
      if (n == 4 && seq[2] == 8'hA0) begin  // status valid from this strobe
        pa = fl_addr;
        pd = dq_out;
        ers = 0;
        go();
      end else if (n == 6) begin  // erase window closes at once
        ers = 1;
        go();
      end
    end
  end
  // a read cycle opens with both strobes low
  always @(negedge oe_b or negedge ce_b) if (!oe_b && !ce_b && we_b) rd = 1;
  // a read cycle closes on either strobe
  always @(posedge oe_b or posedge ce_b) if (rd) begin
    rd = 0;
    last_q = cur;
    if (busy) begin
      tg1 = ~tg1;
      if (ers) tg2 = ~tg2;
      if (stuck) tlim = 1;
      else if (--left == 0) begin             // done: true data back
        busy = 0;
        if (ers) mem.delete();
        else mem[int'(pa)] = pd;
      end
    end
  end
endmodule // flash_model

// ---- sim/flash_status_poller_props.sv ----
// pin and register port checks of the status poller
// assumes it is bound to the poller; one clock, sync reset
`timescale 1ns/1ps
module flash_status_poller_props #(
  parameter AW        = 22,                   // flash address width
  parameter DW        = 8,                    // flash data width
  parameter MAX_POLLS = 16'hFFFF              // read limit
) (
  input wire          sys_clk,                // system clock
  input wire          rst_b,                  // sync reset, active low
  input wire [3:0]    reg_addr,               // register address
  input wire          reg_rd,                 // read strobe
  input wire [31:0]   reg_rdata_q,            // read data
  input wire [AW-1:0] fl_addr,                // address pins
  input wire          dq_oe,                  // data drive enable
  input wire          ce_b,                   // chip enable
  input wire          oe_b,                   // output enable
  input wire          we_b                    // write enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // read strobe low eight clocks
  sequence s_rd_low;
    (!oe_b) [*8] ##1 oe_b;
  endsequence
  // write strobe low five clocks
  sequence s_wr_low;
    (!we_b) [*5] ##1 we_b;
  endsequence
  a_rd_width: assert property ($fell(oe_b) |-> s_rd_low)
    else $error("read strobe width wrong");
  a_wr_width: assert property ($fell(we_b) |-> s_wr_low)
    else $error("write strobe width wrong");
  a_no_overlap: assert property (!(!oe_b && !we_b))
    else $error("read and write strobes overlap");
  a_rd_chip_sel: assert property (!oe_b |-> !ce_b && !dq_oe)
    else $error("read without chip enable or with drive");
  a_wr_drives: assert property (!we_b |-> dq_oe && !ce_b)
    else $error("write without drive or chip enable");
  a_addr_held: assert property (!oe_b && !$past(oe_b) |-> $stable(fl_addr))
    else $error("address moved in a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata_q == 32'h0)
    else $error("unmapped register not zero");
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
    !rst_b |=> ce_b && oe_b && we_b && !dq_oe)
    else $error("pins active after reset");
endmodule // flash_status_poller_props
bind flash_status_poller flash_status_poller_props #(.AW(AW), .DW(DW), .MAX_POLLS(MAX_POLLS))
  chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .fl_addr(fl_addr), .dq_oe(dq_oe), .ce_b(ce_b), .oe_b(oe_b),
  .we_b(we_b));

// ---- sim/tb_top.sv ----
// testbench of the status poller against the flash model
// assumes a 40 mhz clock and a two-cycle reset
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, stuck = 0; // drives
  logic [3:0]  reg_addr = 4'h0;               // register address
  logic [31:0] reg_wdata = 32'h0, rv;         // write data, read value
  wire  [31:0] reg_rdata_q;                   // register read data
  wire  [21:0] fl_addr;                       // flash address
  wire  [7:0]  dq_out, dq_in;                 // flash data
  wire         dq_oe, ce_b, oe_b, we_b, ready_busy_output;
  int          n_start, n_reset, mismatches = 0, n_checks = 0;
  logic [21:0] addrs [3] = '{22'h000123, 22'h010000, 22'h000000}; // per op
  always #12.5 sys_clk = ~sys_clk;
  flash_status_poller #(.MAX_POLLS(16'h0010)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .fl_addr(fl_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
    .ready_busy_output(ready_busy_output));
  flash_model #(.BUSY_READS(3)) flash_u (.fl_addr(fl_addr), .dq_out(dq_out), .ce_b(ce_b),
    .oe_b(oe_b), .we_b(we_b), .stuck(stuck), .dq_in(dq_in),
    .ready_busy_output(ready_busy_output), .n_start(n_start), .n_reset(n_reset));
  // counts, verdict and end of run
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare one value
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle register write
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task reg_read(input logic [3:0] a, output logic [31:0] got);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    got = reg_rdata_q;
  endtask
  // poll the busy bit under a bound
  task wait_idle();
    for (int i = 0; i < 2000; i++) begin
      reg_read(4'h3, rv);
      if (rv[1] === 1'b0) return;
    end
    mismatches++;
    $display("CHECK FAILED busy wait expected 0 seen 1");
    print_verdict();
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_read(4'h3, rv);
    check("status after reset", 32'h0, {29'h0, rv[3:1]});
    reg_read(4'hF, rv);
    check("unmapped read", 32'h0, rv);
    // program, sector erase, chip erase; a second go while busy is dropped
    for (int k = 0; k < 3; k++) begin
      reg_write(4'h1, {10'h0, addrs[k]});
      reg_write(4'h2, 32'h0000005A);
      reg_write(4'h0, 32'h00000008 | (k + 1));
      reg_write(4'h0, 32'h0000000B);
      wait_idle();
      check("op result", 32'h1, {30'h0, rv[3:2]});
      check("op count", k + 1, n_start);
      reg_read(4'h4, rv);
      check("array data", (k == 0) ? 32'h5A : 32'hFF, {24'h0, rv[7:0]});
    end
    // stuck program: limit flag up, toggling persists, reset written
    stuck <= 1'b1;
    reg_write(4'h1, 32'h00000200);
    reg_write(4'h0, 32'h00000009);
    wait_idle();
    check("stuck result", 32'h2, {30'h0, rv[3:2]});
    check("reset commands", 32'h1, n_reset);
    // abort while the flash hangs, then a reset operation brings it back
    reg_write(4'h1, 32'h00000280);
    reg_write(4'h0, 32'h00000009);
    reg_write(4'h0, 32'h00000010);
    wait_idle();
    check("abort result", 32'h0, {30'h0, rv[3:2]});
    reg_write(4'h0, 32'h0000000E);
    wait_idle();
    check("reset op result", 32'h1, {30'h0, rv[3:2]});
    check("reset op commands", 32'h2, n_reset);
    stuck <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reg_read(4'h3, rv);
    check("ready line sync", 32'h1, {31'h0, rv[4]});
    // a fresh poll after failure restarts cleanly
    reg_write(4'h1, 32'h00000300);
    reg_write(4'h0, 32'h00000009);
    wait_idle();
    check("retry result", 32'h1, {30'h0, rv[3:2]});
    print_verdict();
  end
endmodule // tb_top
